// ===== rtl/pio_pkg.sv
// package for the port pin cell block: register map, reset values, pad carrier
// assumes a 32-bit avalon-mm master with word-aligned byte addresses
//
// Contract
// RULE_01: after reset every pin is a digital input, not driven, with its weak pull-up on.
// RULE_02: a per-pin input mode bit selects analog at 0 and digital at 1.
// RULE_03: an analog pin has its weak pull-up and its digital receiver turned off.
// RULE_04: reading an analog pin returns 0 whatever the pad level.
// RULE_05: software should also turn off the output driver of an analog pin; nothing enforces it.
// RULE_06: with output mode 1 a digital pin is push-pull and drives high or low to its value.
// RULE_07: in open-drain mode the high driver is off; value 0 drives low, value 1 floats.
// RULE_08: a floating digital cell has its weak pull-up on, and it is off while driving low.
// RULE_09: the global pull-up disable bit at 1 turns off every weak pull-up.
// RULE_10: the system must keep every digital pin pulled or driven to a valid level.
// RULE_11: reading a digital pin returns the pad level, not the output latch.
// RULE_12: a per-pin drive strength bit picks low or high drive, low after reset.
// RULE_13: there are three byte-wide ports and only ports 0 and 1 may be set analog.
// RULE_14: a digital pin is driven either by an internal peripheral or by software as gpio.
// RULE_15: pin 7 of port 2 is gpio only and shares its pad with the debug data line.
// RULE_16: each port has its own byte-wide input mode, output mode and drive registers.
package pio_pkg;

  localparam int PIO_PORTS = 3;
  localparam int PIO_PINS = 24;
  localparam int PIO_ADDR_W = 8;
  localparam int PIO_DEBUG_PIN = 23;

  // byte offsets; port n of a group sits at base + 4*n
  localparam logic [7:0] PIO_LATCH_BASE = 8'h00;
  localparam logic [7:0] PIO_INMODE_BASE = 8'h0C;
  localparam logic [7:0] PIO_OUTMODE_BASE = 8'h18;
  localparam logic [7:0] PIO_DRIVE_BASE = 8'h24;
  localparam logic [7:0] PIO_PERIPH_BASE = 8'h30;
  localparam logic [7:0] PIO_GLOBAL_OFS = 8'h3C;
  localparam int PIO_GLOBAL_WPUD_BIT = 0;

  // reset values
  localparam logic [23:0] PIO_LATCH_RST = 24'hFFFFFF;
  localparam logic [23:0] PIO_INMODE_RST = 24'hFFFFFF;
  localparam logic [23:0] PIO_OUTMODE_RST = 24'h000000;
  localparam logic [23:0] PIO_DRIVE_RST = 24'h000000;
  localparam logic [23:0] PIO_PERIPH_RST = 24'h000000;
  // port 2 can never be analog, and its pin 7 never goes to a peripheral
  localparam logic [23:0] PIO_ANALOG_CAPABLE = 24'h00FFFF;
  localparam logic [23:0] PIO_PERIPH_CAPABLE = 24'h7FFFFF;
  localparam logic [31:0] PIO_RDATA_RST = 32'h00000000;

  typedef enum logic [2:0] {
    PIO_GRP_LATCH,
    PIO_GRP_INMODE,
    PIO_GRP_OUTMODE,
    PIO_GRP_DRIVE,
    PIO_GRP_PERIPH,
    PIO_GRP_GLOBAL,
    PIO_GRP_NONE
  } pio_grp_t;

  // everything the pad ring needs per pin, bit n = pin n (port*8 + index)
  typedef struct packed {
    logic [23:0] out;        // level driven when the driver is on
    logic [23:0] oe_n;       // low while the cell drives the pad
    logic [23:0] pullup_en;  // weak pull-up on
    logic [23:0] hi_drive;   // high drive strength
    logic [23:0] rx_en;      // digital receiver on
  } pio_pad_t;

  localparam pio_pad_t PIO_PAD_RST = '{
    out: 24'h000000,
    oe_n: 24'hFFFFFF,
    pullup_en: 24'hFFFFFF,
    hi_drive: 24'h000000,
    rx_en: 24'hFFFFFF
  };

endpackage

// ===== rtl/pio_port_cells.sv
// port pin cell logic for three byte-wide ports with an avalon-mm register slave
// assumes pad ring resolves the wire from out/oe_n/pullup_en; pad inputs are asynchronous
`timescale 1ns/1ps
module pio_port_cells (
  input wire logic clock,                                   // 50 MHz system clock
  input wire logic nrst,                                    // async reset, active low
  input wire logic [pio_pkg::PIO_ADDR_W-1:0] avs_address,   // byte address
  input wire logic avs_read,                                // read request
  input wire logic avs_write,                               // write request
  input wire logic [31:0] avs_writedata,                    // write data
  input wire logic [3:0] avs_byteenable,                    // byte lanes of the write
  output logic [31:0] avs_readdata,                         // read data
  output logic avs_waitrequest,                             // stall
  input wire logic [pio_pkg::PIO_PINS-1:0] pad_in,          // pad levels, asynchronous
  output pio_pkg::pio_pad_t pad_ctrl,                       // pad drivers and pull-ups
  input wire logic [pio_pkg::PIO_PINS-1:0] periph_out,      // peripheral output values
  output logic [pio_pkg::PIO_PINS-1:0] periph_in,           // synced pad levels to peripherals
  input wire logic debug_active,                            // debug owns the shared pin
  input wire logic debug_data_out,                          // debug data to drive
  input wire logic debug_data_oe,                           // debug drives the data pin
  output logic debug_data_pin                               // synced debug data pad level
);
  import pio_pkg::*;

  // configuration group
  logic [23:0] latch_reg, latch_next;
  logic [23:0] in_mode_reg, in_mode_next;
  logic [23:0] out_mode_reg, out_mode_next;
  logic [23:0] drive_reg, drive_next;
  logic [23:0] periph_reg, periph_next;
  logic wpud_reg, wpud_next;
  // bus group
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  // synchroniser and pad group
  logic [23:0] sync1_reg, sync2_reg;
  pio_pad_t pad_reg, pad_next;

  pio_grp_t grp;
  logic [1:0] port_sel;
  logic bus_req;

  // decode a byte offset into a register group and a port number
  function automatic pio_grp_t decode_grp(input logic [7:0] a);
    if (a[1:0] != 2'b00) begin
      decode_grp = PIO_GRP_NONE;
    end else if (a >= PIO_LATCH_BASE && a < PIO_INMODE_BASE) begin
      decode_grp = PIO_GRP_LATCH;
    end else if (a >= PIO_INMODE_BASE && a < PIO_OUTMODE_BASE) begin
      decode_grp = PIO_GRP_INMODE;
    end else if (a >= PIO_OUTMODE_BASE && a < PIO_DRIVE_BASE) begin
      decode_grp = PIO_GRP_OUTMODE;
    end else if (a >= PIO_DRIVE_BASE && a < PIO_PERIPH_BASE) begin
      decode_grp = PIO_GRP_DRIVE;
    end else if (a >= PIO_PERIPH_BASE && a < PIO_GLOBAL_OFS) begin
      decode_grp = PIO_GRP_PERIPH;
    end else if (a == PIO_GLOBAL_OFS) begin
      decode_grp = PIO_GRP_GLOBAL;
    end else begin
      decode_grp = PIO_GRP_NONE;
    end
  endfunction

  function automatic logic [1:0] decode_port(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] rel;
    rel = a - base;
    decode_port = rel[3:2];
  endfunction

  // replace one byte of a 24-bit per-pin vector
  function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] p,
                                           input logic [7:0] b);
    logic [23:0] r;
    r = v;
    case (p)
      2'd0: r[7:0] = b;
      2'd1: r[15:8] = b;
      default: r[23:16] = b;
    endcase
    put_byte = r;
  endfunction

  function automatic logic [7:0] get_byte(input logic [23:0] v, input logic [1:0] p);
    case (p)
      2'd0: get_byte = v[7:0];
      2'd1: get_byte = v[15:8];
      default: get_byte = v[23:16];
    endcase
  endfunction

  always_comb begin
    grp = decode_grp(avs_address);
    case (grp)
      PIO_GRP_LATCH: port_sel = decode_port(avs_address, PIO_LATCH_BASE);
      PIO_GRP_INMODE: port_sel = decode_port(avs_address, PIO_INMODE_BASE);
      PIO_GRP_OUTMODE: port_sel = decode_port(avs_address, PIO_OUTMODE_BASE);
      PIO_GRP_DRIVE: port_sel = decode_port(avs_address, PIO_DRIVE_BASE);
      PIO_GRP_PERIPH: port_sel = decode_port(avs_address, PIO_PERIPH_BASE);
      default: port_sel = 2'd0;
    endcase
  end

  // one wait cycle per access: data is fetched in the first cycle, write lands in the second
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign avs_readdata = rdata_reg;

  always_comb begin
    latch_next = latch_reg;
    in_mode_next = in_mode_reg;
    out_mode_next = out_mode_reg;
    drive_next = drive_reg;
    periph_next = periph_reg;
    wpud_next = wpud_reg;
    ack_next = bus_req & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read && !ack_reg) begin
      rdata_next = PIO_RDATA_RST;
      case (grp)
        // digital pins read the pad, analog pins read 0
        PIO_GRP_LATCH: rdata_next[7:0] = get_byte(sync2_reg & in_mode_reg, port_sel); // RULE_04 RULE_11
        PIO_GRP_INMODE: rdata_next[7:0] = get_byte(in_mode_reg, port_sel);
        PIO_GRP_OUTMODE: rdata_next[7:0] = get_byte(out_mode_reg, port_sel);
        PIO_GRP_DRIVE: rdata_next[7:0] = get_byte(drive_reg, port_sel);
        PIO_GRP_PERIPH: rdata_next[7:0] = get_byte(periph_reg, port_sel);
        PIO_GRP_GLOBAL: rdata_next[PIO_GLOBAL_WPUD_BIT] = wpud_reg;
        default: rdata_next = PIO_RDATA_RST;
      endcase
    end
    if (avs_write && ack_reg && avs_byteenable[0]) begin
      case (grp)
        PIO_GRP_LATCH: latch_next = put_byte(latch_reg, port_sel, avs_writedata[7:0]);
        // port 2 bits stay digital whatever is written
        PIO_GRP_INMODE: in_mode_next = put_byte(in_mode_reg, port_sel, avs_writedata[7:0])
                                       | ~PIO_ANALOG_CAPABLE; // RULE_02 RULE_13 RULE_16
        PIO_GRP_OUTMODE: out_mode_next = put_byte(out_mode_reg, port_sel,
                                                  avs_writedata[7:0]); // RULE_16
        PIO_GRP_DRIVE: drive_next = put_byte(drive_reg, port_sel, avs_writedata[7:0]); // RULE_12
        PIO_GRP_PERIPH: periph_next = put_byte(periph_reg, port_sel, avs_writedata[7:0])
                                      & PIO_PERIPH_CAPABLE; // RULE_14 RULE_15
        PIO_GRP_GLOBAL: wpud_next = avs_writedata[PIO_GLOBAL_WPUD_BIT]; // RULE_09
        default: latch_next = latch_reg;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      latch_reg <= PIO_LATCH_RST; // RULE_01
      in_mode_reg <= PIO_INMODE_RST; // RULE_01
      out_mode_reg <= PIO_OUTMODE_RST;
      drive_reg <= PIO_DRIVE_RST; // RULE_12
      periph_reg <= PIO_PERIPH_RST;
      wpud_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= PIO_RDATA_RST;
    end else begin
      latch_reg <= latch_next;
      in_mode_reg <= in_mode_next;
      out_mode_reg <= out_mode_next;
      drive_reg <= drive_next;
      periph_reg <= periph_next;
      wpud_reg <= wpud_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // pad levels are asynchronous; only the second stage feeds logic
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 24'h000000;
      sync2_reg <= 24'h000000;
    end else begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
    end
  end

  // pad control; the driver is not gated by analog mode, software must turn it off itself
  always_comb begin
    logic [23:0] val;
    logic [23:0] drv_low;
    logic [23:0] drv_high;
    val = (periph_reg & periph_out) | (~periph_reg & latch_reg); // RULE_14
    drv_low = ~val; // RULE_07
    drv_high = val & out_mode_reg; // RULE_06
    // shared debug data pin: the debug port takes the cell while active
    if (debug_active) begin
      drv_low[PIO_DEBUG_PIN] = debug_data_oe & ~debug_data_out; // RULE_15
      drv_high[PIO_DEBUG_PIN] = debug_data_oe & debug_data_out; // RULE_15
    end
    pad_next.out = drv_high;
    pad_next.oe_n = ~(drv_low | drv_high);
    pad_next.pullup_en = in_mode_reg & ~drv_low & {PIO_PINS{~wpud_reg}}; // RULE_03 RULE_08 RULE_09
    pad_next.hi_drive = drive_reg; // RULE_12
    pad_next.rx_en = in_mode_reg; // RULE_03
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pad_reg <= PIO_PAD_RST; // RULE_01
    end else begin
      pad_reg <= pad_next;
    end
  end

  assign pad_ctrl = pad_reg;
  // receivers off on analog pins, so peripherals see 0 there too
  assign periph_in = sync2_reg & in_mode_reg; // RULE_03
  assign debug_data_pin = sync2_reg[PIO_DEBUG_PIN];

endmodule

// ===== bench/pio_cells_chk_properties.sv
// checker for the port pin cells: bus wait, reset pads, pull-up and input sync relations
// assumes it is bound into every pio_port_cells instance and sees its ports only
`timescale 1ns/1ps
module pio_cells_chk
  import pio_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic [PIO_PINS-1:0] pad_in, // pad levels
  input wire pio_pad_t pad_ctrl, // pad drivers
  input wire logic [PIO_PINS-1:0] periph_in, // synced pad levels
  input wire logic debug_data_pin // synced shared pin
);
  // sync stages hold stale levels for the first edges after reset
  logic [1:0] age_reg;
  logic [1:0] age_next;
  always_comb age_next = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) age_reg <= 2'h0;
    else age_reg <= age_next;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request finished without a wait cycle");
  wait_once_a: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("wait lasted more than one cycle");
  rdata_high_a: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("read data above the byte not zero");
  reset_pads_a: assert property ($rose(nrst) |-> pad_ctrl == PIO_PAD_RST)
    else $error("pads not in input state after reset");
  reset_drive_a: assert property ($rose(nrst) |-> pad_ctrl.hi_drive == 24'h000000)
    else $error("high drive after reset");
  analog_pull_a: assert property ((pad_ctrl.pullup_en & ~pad_ctrl.rx_en) == 24'h000000)
    else $error("pull-up on an analog pin");
  low_pull_a: assert property ((pad_ctrl.pullup_en & ~pad_ctrl.oe_n & ~pad_ctrl.out) == 24'h0)
    else $error("pull-up on while driving low");
  pad_read_a: assert property (age_reg == 2'h3 |-> (periph_in & ~$past(pad_in, 2)) == 24'h0)
    else $error("input high without pad level");
  debug_sync_a: assert property (age_reg == 2'h3 |-> debug_data_pin == $past(pad_in[23], 2))
    else $error("shared pin level not synced");
  cover property (avs_write && !avs_waitrequest);
  cover property (pad_ctrl.rx_en != 24'hFFFFFF);
  cover property ((~pad_ctrl.oe_n & pad_ctrl.out) != 24'h000000);
endmodule
bind pio_port_cells pio_cells_chk u_chk (.clock(clock), .nrst(nrst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pad_in(pad_in), .pad_ctrl(pad_ctrl), .periph_in(periph_in), .debug_data_pin(debug_data_pin));

// ===== bench/pio_pad_load.sv
// external loads on the pads: resolves each wire from cell and outside drivers
// assumes the bench keeps every digital pin driven or pulled
`timescale 1ns/1ps
module pio_pad_load
  import pio_pkg::*;
(
  input wire logic clock, // system clock
  input wire pio_pad_t pad_ctrl, // cell drivers
  input wire logic [23:0] ext_oe, // outside driver on
  input wire logic [23:0] ext_val, // outside level
  output logic [23:0] pad_in // wire levels
);
  // a truly floating pad wanders, so it must never be trusted
  logic flt_reg = 1'b0;
  always @(posedge clock) flt_reg <= ~flt_reg;
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pad_in[i] = !pad_ctrl.oe_n[i] ? pad_ctrl.out[i] : ext_oe[i] ? ext_val[i] :
        pad_ctrl.pullup_en[i] ? 1'b1 : flt_reg;
    end
  end
endmodule

// ===== bench/port_pin_io_cell_modes_test.sv
// self-checking bench for the port pin cells: random pin setups plus corner accesses
// assumes pio_pad_load stands on the pads and the checker is bound in
`timescale 1ns/1ps
module port_pin_io_cell_modes_test;
  import pio_pkg::*;
  localparam logic [7:0] BASE [5] = '{PIO_LATCH_BASE, PIO_INMODE_BASE, PIO_OUTMODE_BASE,
    PIO_DRIVE_BASE, PIO_PERIPH_BASE};
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic wreq, wpud, dpin;
  logic dbg_act = 1'b0;
  logic dbg_out = 1'b0;
  logic dbg_oe = 1'b0;
  logic [23:0] pin_in;
  logic [23:0] pad, pout = 24'h0, ext_oe = 24'h0, ext_val = 24'h0, lat, inm, outm, drv, per;
  pio_pad_t pctl;
  int n_fail = 0;
  int tests_run = 0;
  always #10 clock = ~clock;
  pio_port_cells u_dut (.clock(clock), .nrst(nrst), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .pad_in(pad), .pad_ctrl(pctl), .periph_out(pout), .periph_in(pin_in),
    .debug_active(dbg_act), .debug_data_out(dbg_out), .debug_data_oe(dbg_oe),
    .debug_data_pin(dpin));
  pio_pad_load u_load (.clock(clock), .pad_ctrl(pctl), .ext_oe(ext_oe), .ext_val(ext_val),
    .pad_in(pad));
  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pad(string nm, logic [23:0] e, logic [23:0] g);
    chk_word(nm, {8'h00, e}, {8'h00, g});
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] b,
                     output logic [31:0] q);
    int k;
    k = 0;
    addr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clock);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    if (k >= 50) begin
      n_fail++;
      summarize();
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
  endtask
  function automatic pio_pad_t exp_pad();
    pio_pad_t e;
    logic [23:0] lo;
    logic [23:0] hi;
    lo = ~((per & pout) | (~per & lat));
    hi = ~lo & outm;
    // the debug port owns the shared pin's drivers while active
    if (dbg_act) begin
      lo[23] = dbg_oe & ~dbg_out;
      hi[23] = dbg_oe & dbg_out;
    end
    e.out = hi;
    e.oe_n = ~(lo | hi);
    e.pullup_en = inm & ~lo & {24{~wpud}};
    e.hi_drive = drv;
    e.rx_en = inm;
    return e;
  endfunction
  task automatic chk_all();
    pio_pad_t e;
    logic [23:0] lvl;
    logic [31:0] q;
    e = exp_pad();
    lvl = (~e.oe_n & e.out) | (e.oe_n & ext_oe & ext_val) | (e.oe_n & ~ext_oe & e.pullup_en);
    chk_pad("out", e.out, pctl.out);
    chk_pad("oe_n", e.oe_n, pctl.oe_n);
    chk_pad("pullup", e.pullup_en, pctl.pullup_en);
    chk_pad("drive", e.hi_drive, pctl.hi_drive);
    chk_pad("rx", e.rx_en, pctl.rx_en);
    chk_pad("periph_in", lvl & inm, pin_in);
    chk_word("debug pin", {31'h0, lvl[23]}, {31'h0, dpin});
    for (int p = 0; p < 3; p++) begin
      bus(1'b0, PIO_LATCH_BASE + 8'(4 * p), 32'h0, 4'h0, q);
      chk_word("pin read", {24'h0, lvl[8 * p +: 8] & inm[8 * p +: 8]}, q);
    end
  endtask
  initial begin
    logic [31:0] q;
    logic [23:0] wv [5];
    pio_pad_t e;
    lat = 24'hFFFFFF;
    inm = lat;
    {outm, drv, per, wpud} = '0;
    void'($urandom(32'h703A020A));
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    // refused accesses must leave the reset setup untouched
    bus(1'b1, 8'h40, 32'h0, 4'h1, q);
    bus(1'b1, PIO_LATCH_BASE, 32'h0, 4'h0, q);
    bus(1'b0, 8'h41, 32'h0, 4'h0, q);
    chk_word("unmapped", 32'h0, q);
    chk_all();
    $display("test reset done");
    for (int t = 0; t < 40; t++) begin
      pout <= 24'($urandom());
      dbg_act <= 1'($urandom());
      dbg_out <= 1'($urandom());
      dbg_oe <= 1'($urandom());
      wv[1] = $urandom();
      inm = wv[1] | ~PIO_ANALOG_CAPABLE;
      outm = $urandom() & inm;
      lat = $urandom() | ~inm;
      drv = 24'($urandom());
      wv[4] = $urandom() & inm;
      per = wv[4] & PIO_PERIPH_CAPABLE;
      wpud = 1'($urandom());
      wv[0] = lat;
      wv[2] = outm;
      wv[3] = drv;
      for (int p = 0; p < 3; p++) begin
        for (int g = 0; g < 5; g++) begin
          bus(1'b1, BASE[g] + 8'(4 * p), {24'h0, wv[g][8 * p +: 8]}, 4'h1, q);
        end
      end
      bus(1'b1, PIO_GLOBAL_OFS, {31'h0, wpud}, 4'h1, q);
      e = exp_pad();
      ext_val <= $urandom();
      ext_oe <= e.oe_n & (~e.pullup_en | 24'($urandom()));
      repeat (4) @(posedge clock);
      chk_all();
      $display("test random %0d done", t);
    end
    summarize();
  end
endmodule
